// File: hw/sxalu_cfg.svh
`ifndef SXALU_CFG_SVH
`define SXALU_CFG_SVH
`define SXALU_PFX_XOR_MEM 9'h070
`define SXALU_PFX_XOR_MEM_WB 9'h072
`define SXALU_PFX_XOR_WR 8'h3c
`define SXALU_PFX_XOR_WR_WB 8'h3d
`define SXALU_PFX_SUB_WB 8'h1f
`define SXALU_ACC_RST 4'h0
`endif

// File: hw/sxalu_pkg.sv
package sxalu_pkg;
    typedef enum logic [2:0] {
        SXALU_NONE = 3'h0,
        SXALU_SUB_WB = 3'h1,
        SXALU_XOR_MEM = 3'h3,
        SXALU_XOR_MEM_WB = 3'h2,
        SXALU_XOR_WR = 3'h6,
        SXALU_XOR_WR_WB = 3'h7
    } sxalu_op_t;
endpackage

// File: hw/sxalu_ram.sv
`include "sxalu_cfg.svh"
// Data memory, 128 nibbles; the low 16 are the working registers.
// Two registered read ports: one by address, one by register index.
module sxalu_ram (
    // Clock
    input wire logic clk,
    // Read ports
    input wire logic [6:0] rd_addr,
    output logic [3:0] rd_data,
    input wire logic [3:0] wr_idx_rd,
    output logic [3:0] wr_data_rd,
    // Write port
    input wire logic we,
    input wire logic [6:0] wa,
    input wire logic [3:0] wd
);
    logic [3:0] mem [0:127];
    // No reset on storage; the core initialises RAM by software.
    // The array is written in a plain clocked process so that it can also be preloaded from outside.
    always @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    // Registered read ports
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
        wr_data_rd <= mem[{3'h0, wr_idx_rd}];
    end
endmodule

// File: hw/sxalu_top.sv
`include "sxalu_cfg.svh"
// Two-stage: cycle 0 the instruction is latched and operands read,
// cycle 1 the result is written. Back-to-back issue is allowed;
// a following instruction reading the just-written nibble sees the
// old value (no forwarding; limitation of the registered RAM read).
module sxalu_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    // Results
    output logic [3:0] acc,
    output logic carry_flag,
    output logic zero_flag,
    output logic done,
    output logic mem_we,
    output logic [6:0] mem_wa,
    output logic [3:0] mem_wd
);
    //--------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------
    sxalu_pkg::sxalu_op_t dec_op;
    // Prefixes are disjoint, so the order of the tests does not matter
    always_comb begin
        dec_op = sxalu_pkg::SXALU_NONE;
        if (!instr_valid) begin
            dec_op = sxalu_pkg::SXALU_NONE;
        end else if (instr[15:7] == `SXALU_PFX_XOR_MEM) begin
            dec_op = sxalu_pkg::SXALU_XOR_MEM;
        end else if (instr[15:7] == `SXALU_PFX_XOR_MEM_WB) begin
            dec_op = sxalu_pkg::SXALU_XOR_MEM_WB;
        end else if (instr[15:8] == `SXALU_PFX_XOR_WR) begin
            dec_op = sxalu_pkg::SXALU_XOR_WR;
        end else if (instr[15:8] == `SXALU_PFX_XOR_WR_WB) begin
            dec_op = sxalu_pkg::SXALU_XOR_WR_WB;
        end else if (instr[15:8] == `SXALU_PFX_SUB_WB) begin
            dec_op = sxalu_pkg::SXALU_SUB_WB;
        end
    end

    //--------------------------------------------------------------
    // Operand fetch
    //--------------------------------------------------------------
    logic [3:0] mem_rd;
    logic [3:0] wr_rd;
    sxalu_ram u_ram (
        .clk(clk),
        .rd_addr(instr[6:0]),
        .rd_data(mem_rd),
        .wr_idx_rd(instr[3:0]),
        .wr_data_rd(wr_rd),
        .we(mem_we),
        .wa(mem_wa),
        .wd(mem_wd)
    );

    sxalu_pkg::sxalu_op_t op;
    logic [3:0] imm;
    logic [6:0] addr;
    // Latch the operation and its fields on the same edge as the RAM reads
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op <= sxalu_pkg::SXALU_NONE;
            imm <= 4'h0;
            addr <= 7'h00;
        end else begin
            op <= dec_op;
            imm <= instr[7:4];
            addr <= instr[6:0];
        end
    end

    //--------------------------------------------------------------
    // Execute and write back
    //--------------------------------------------------------------
    logic [3:0] next_acc;
    logic next_carry_flag;
    logic next_zero_flag;
    logic next_mem_we;
    logic [6:0] next_mem_wa;
    logic [3:0] next_mem_wd;
    logic [4:0] diff;
    // Next results; every XOR form leaves carry alone
    always_comb begin
        next_acc = acc;
        next_carry_flag = carry_flag;
        next_zero_flag = zero_flag;
        next_mem_we = 1'b0;
        next_mem_wa = mem_wa;
        next_mem_wd = mem_wd;
        diff = {1'b0, wr_rd} - {1'b0, imm};
        case (op)
            sxalu_pkg::SXALU_SUB_WB: begin
                next_acc = diff[3:0];
                next_carry_flag = ~diff[4];
                next_mem_we = 1'b1;
                next_mem_wa = {3'h0, addr[3:0]};
                next_mem_wd = diff[3:0];
            end
            sxalu_pkg::SXALU_XOR_MEM: begin
                next_acc = mem_rd ^ acc;
            end
            sxalu_pkg::SXALU_XOR_MEM_WB: begin
                next_acc = mem_rd ^ acc;
                next_mem_we = 1'b1;
                next_mem_wa = addr;
                next_mem_wd = mem_rd ^ acc;
            end
            sxalu_pkg::SXALU_XOR_WR: begin
                next_acc = wr_rd ^ imm;
            end
            sxalu_pkg::SXALU_XOR_WR_WB: begin
                next_acc = wr_rd ^ imm;
                next_mem_we = 1'b1;
                next_mem_wa = {3'h0, addr[3:0]};
                next_mem_wd = wr_rd ^ imm;
            end
            default: begin
                next_acc = acc;
            end
        endcase
        if (op != sxalu_pkg::SXALU_NONE) begin
            next_zero_flag = (next_acc == 4'h0);
        end
    end

    // Result registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= `SXALU_ACC_RST;
            carry_flag <= 1'b0;
            zero_flag <= 1'b0;
            done <= 1'b0;
            mem_we <= 1'b0;
            mem_wa <= 7'h00;
            mem_wd <= 4'h0;
        end else begin
            acc <= next_acc;
            carry_flag <= next_carry_flag;
            zero_flag <= next_zero_flag;
            done <= (op != sxalu_pkg::SXALU_NONE);
            mem_we <= next_mem_we;
            mem_wa <= next_mem_wa;
            mem_wd <= next_mem_wd;
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    // Per-instruction results, one cycle after the operand phase
    a_sub_carry: assert property (@(posedge clk) disable iff (!rst_b)
        op == sxalu_pkg::SXALU_SUB_WB |=> carry_flag == ($past(wr_rd) >= $past(imm)))
        else $error("carry wrong after subtract");
    a_sub_wb: assert property (@(posedge clk) disable iff (!rst_b)
        op == sxalu_pkg::SXALU_SUB_WB |=> mem_we && mem_wd == acc && mem_wa == {3'h0, $past(addr[3:0])}
            && acc == ($past(wr_rd) - $past(imm)))
        else $error("subtract write-back missing");
    a_xor_mem_nowb: assert property (@(posedge clk) disable iff (!rst_b)
        op == sxalu_pkg::SXALU_XOR_MEM |=> !mem_we && acc == ($past(mem_rd) ^ $past(acc)))
        else $error("memory xor wrong");
    a_xor_wr_nowb: assert property (@(posedge clk) disable iff (!rst_b)
        op == sxalu_pkg::SXALU_XOR_WR |=> !mem_we && acc == ($past(wr_rd) ^ $past(imm)))
        else $error("register xor wrong");
    a_xor_mem_wb: assert property (@(posedge clk) disable iff (!rst_b)
        op == sxalu_pkg::SXALU_XOR_MEM_WB |=> mem_we && mem_wd == acc && mem_wa == $past(addr)
            && acc == ($past(mem_rd) ^ $past(acc)))
        else $error("memory xor write-back wrong");
    a_xor_wr_wb: assert property (@(posedge clk) disable iff (!rst_b)
        op == sxalu_pkg::SXALU_XOR_WR_WB |=> mem_we && mem_wd == acc && mem_wa == {3'h0, $past(addr[3:0])}
            && acc == ($past(wr_rd) ^ $past(imm)))
        else $error("register xor write-back wrong");
    a_xor_carry_kept: assert property (@(posedge clk) disable iff (!rst_b)
        op inside {sxalu_pkg::SXALU_XOR_MEM, sxalu_pkg::SXALU_XOR_WR, sxalu_pkg::SXALU_XOR_MEM_WB,
            sxalu_pkg::SXALU_XOR_WR_WB} |=> $stable(carry_flag))
        else $error("xor touched carry");
    a_zero_flag: assert property (@(posedge clk) disable iff (!rst_b)
        op != sxalu_pkg::SXALU_NONE |=> zero_flag == (acc == 4'h0))
        else $error("zero flag wrong");
    a_dec_mem: assert property (@(posedge clk) disable iff (!rst_b)
        instr_valid && instr[15:7] == `SXALU_PFX_XOR_MEM |=> op == sxalu_pkg::SXALU_XOR_MEM ##1 done)
        else $error("decode of memory xor wrong");
    a_dec_wb: assert property (@(posedge clk) disable iff (!rst_b)
        instr_valid && instr[15:7] == `SXALU_PFX_XOR_MEM_WB |=> op == sxalu_pkg::SXALU_XOR_MEM_WB)
        else $error("decode of memory xor write-back wrong");
    a_dec_wr: assert property (@(posedge clk) disable iff (!rst_b)
        instr_valid && instr[15:8] == `SXALU_PFX_XOR_WR |=> op == sxalu_pkg::SXALU_XOR_WR)
        else $error("decode of register xor wrong");
    a_dec_wrwb: assert property (@(posedge clk) disable iff (!rst_b)
        instr_valid && instr[15:8] == `SXALU_PFX_XOR_WR_WB |=> op == sxalu_pkg::SXALU_XOR_WR_WB)
        else $error("decode of register xor write-back wrong");
    a_dec_sub: assert property (@(posedge clk) disable iff (!rst_b)
        instr_valid && instr[15:8] == `SXALU_PFX_SUB_WB |=> op == sxalu_pkg::SXALU_SUB_WB)
        else $error("decode of subtract wrong");
    c_sub: cover property (@(posedge clk) disable iff (!rst_b) op == sxalu_pkg::SXALU_SUB_WB ##1 !carry_flag);
    c_xor_zero: cover property (@(posedge clk) disable iff (!rst_b) op == sxalu_pkg::SXALU_XOR_MEM ##1 zero_flag);
    c_wb_b2b: cover property (@(posedge clk) disable iff (!rst_b) mem_we ##1 mem_we);
    c_xor_wr_wb: cover property (@(posedge clk) disable iff (!rst_b) op == sxalu_pkg::SXALU_XOR_WR_WB ##1 mem_we);
    c_foreign: cover property (@(posedge clk) disable iff (!rst_b) instr_valid ##1 op == sxalu_pkg::SXALU_NONE);

    // Quiet cycles, completion strobe, refused words and the held write port
    // An idle operand phase leaves every result alone and raises no strobe
    a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        op == sxalu_pkg::SXALU_NONE |=> !done && !mem_we && $stable(acc) && $stable(zero_flag))
        else $error("idle cycle changed a result");
    // Every decoded operation finishes in one execute cycle
    a_done_follows: assert property (@(posedge clk) disable iff (!rst_b)
        op != sxalu_pkg::SXALU_NONE |=> done)
        else $error("done missing after an operation");
    // Words outside the five prefixes are dropped silently
    a_foreign_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        instr_valid && instr[15:7] != `SXALU_PFX_XOR_MEM && instr[15:7] != `SXALU_PFX_XOR_MEM_WB
            && instr[15:8] != `SXALU_PFX_XOR_WR && instr[15:8] != `SXALU_PFX_XOR_WR_WB
            && instr[15:8] != `SXALU_PFX_SUB_WB |=> op == sxalu_pkg::SXALU_NONE)
        else $error("unknown word was decoded");
    // Write address and data hold between write strobes
    a_wb_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !mem_we |-> $stable(mem_wa) && $stable(mem_wd))
        else $error("write port moved without a strobe");
endmodule

// File: sim/sxalu_top_test.sv
module sxalu_top_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [3:0] acc;
    logic carry_flag;
    logic zero_flag;
    logic done;
    logic mem_we;
    logic [6:0] mem_wa;
    logic [3:0] mem_wd;
    int err_count = 0;
    int n_tests = 0;

    sxalu_top dut (
        .clk(clk),
        .rst_b(rst_b),
        .instr_valid(instr_valid),
        .instr(instr),
        .acc(acc),
        .carry_flag(carry_flag),
        .zero_flag(zero_flag),
        .done(done),
        .mem_we(mem_we),
        .mem_wa(mem_wa),
        .mem_wd(mem_wd)
    );

    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Issue one word and wait, bounded, for its done pulse; outputs are read after it settles
    task automatic issue(input logic [15:0] w, input logic want);
        int i;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        for (i = 0; i < 6; i++) begin
            #1;
            if (done === 1'b1) break;
            @(posedge clk);
        end
        #1;
        chk("done", {7'h00, want}, {7'h00, done});
        if (want && done !== 1'b1) report_and_stop();
    endtask

    // Compare accumulator, both flags and the write strobe of the last operation
    task automatic expect_res(input logic [3:0] a, input logic c, input logic z, input logic we);
        chk("acc", {4'h0, a}, {4'h0, acc});
        chk("carry_flag", {7'h00, c}, {7'h00, carry_flag});
        chk("zero_flag", {7'h00, z}, {7'h00, zero_flag});
        chk("mem_we", {7'h00, we}, {7'h00, mem_we});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Subtract with write-back: no borrow, borrow, zero result
    task automatic t_sub();
        dut.u_ram.mem[3] = 4'h5;
        dut.u_ram.mem[4] = 4'h1;
        dut.u_ram.mem[5] = 4'h2;
        issue(16'h1f23, 1'b1);
        expect_res(4'h3, 1'b1, 1'b0, 1'b1);
        chk("mem_wa", 8'h03, {1'b0, mem_wa});
        chk("mem_wd", 8'h03, {4'h0, mem_wd});
        issue(16'h1f24, 1'b1);
        expect_res(4'hf, 1'b0, 1'b0, 1'b1);
        issue(16'h1f25, 1'b1);
        expect_res(4'h0, 1'b1, 1'b1, 1'b1);
    endtask

    // Memory XOR into accumulator only; carry left alone
    task automatic t_xor_mem();
        dut.u_ram.mem[69] = 4'ha;
        issue(16'h3845, 1'b1);
        expect_res(4'ha, 1'b1, 1'b0, 1'b0);
        issue(16'h3845, 1'b1);
        expect_res(4'h0, 1'b1, 1'b1, 1'b0);
    endtask

    // Register XOR immediate; the register must not change
    task automatic t_xor_reg();
        dut.u_ram.mem[7] = 4'h9;
        issue(16'h3c67, 1'b1);
        expect_res(4'hf, 1'b1, 1'b0, 1'b0);
        issue(16'h3c97, 1'b1);
        expect_res(4'h0, 1'b1, 1'b1, 1'b0);
    endtask

    // Memory XOR with write-back at address 126, one below the top address
    task automatic t_xor_mem_wb();
        dut.u_ram.mem[126] = 4'h3;
        issue(16'h397e, 1'b1);
        expect_res(4'h3, 1'b1, 1'b0, 1'b1);
        chk("mem_wa", 8'h7e, {1'b0, mem_wa});
        chk("mem_wd", 8'h03, {4'h0, mem_wd});
    endtask

    // Register XOR with write-back, then read the register back
    task automatic t_xor_reg_wb();
        dut.u_ram.mem[2] = 4'h5;
        issue(16'h3dc2, 1'b1);
        expect_res(4'h9, 1'b1, 1'b0, 1'b1);
        chk("mem_wa", 8'h02, {1'b0, mem_wa});
        chk("mem_wd", 8'h09, {4'h0, mem_wd});
        issue(16'h3c02, 1'b1);
        expect_res(4'h9, 1'b1, 1'b0, 1'b0);
    endtask

    // Neighbouring words outside this block give no done and change nothing
    task automatic t_foreign();
        issue(16'h3b00, 1'b0);
        issue(16'h1e23, 1'b0);
        expect_res(4'h9, 1'b1, 1'b0, 1'b0);
    endtask

    // Back-to-back write-backs: the second uses the accumulator left by the first
    task automatic t_b2b();
        dut.u_ram.mem[8] = 4'h6;
        dut.u_ram.mem[9] = 4'h3;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= 16'h3d18;
        @(posedge clk);
        instr <= 16'h3909;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("done", 8'h01, {7'h00, done});
        expect_res(4'h7, 1'b1, 1'b0, 1'b1);
        chk("mem_wa", 8'h08, {1'b0, mem_wa});
        chk("mem_wd", 8'h07, {4'h0, mem_wd});
        @(posedge clk);
        #1;
        chk("done", 8'h01, {7'h00, done});
        expect_res(4'h4, 1'b1, 1'b0, 1'b1);
        chk("mem_wa", 8'h09, {1'b0, mem_wa});
        chk("mem_wd", 8'h04, {4'h0, mem_wd});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        expect_res(4'h0, 1'b0, 1'b0, 1'b0);
        t_sub();
        t_xor_mem();
        t_xor_reg();
        t_xor_mem_wb();
        t_xor_reg_wb();
        t_foreign();
        t_b2b();
        report_and_stop();
    end
endmodule
